// File: bench/gcd_config_regs_bench.sv
// self-checking bench for the gain / chop / detect register bank
// assumes the bank alone on a 20 MHz clock, reached through APB
module gcd_config_regs_bench
    import gcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    gcd_apb_req_t apb = '0;
    logic mod_tick = 1'b0;
    logic chop_start = 1'b0;
    logic conv_strobe = 1'b0;
    logic [3:0] ch_over = 4'h0;
    logic o_pready, o_pslverr, settled, det_pulse, det_seen, err;
    logic [31:0] o_prdata, rd, d;
    gcd_cfg_t cfg;
    logic [15:0] g;
    logic [15:0] shadow [3];
    logic [3:0] s;
    int n_errors = 0, n_tests = 0, cyc = 0, np = 0, j, k, p0;
    logic [7:0] adr [3] = '{GAIN_ADDR, SPARE_ADDR, CFG_ADDR};
    logic [11:0] wt [8] = '{12'h080, 12'h100, 12'h200, 12'h300, 12'h500, 12'h700, 12'ha00,
        12'he00};
    // detect cases: cfg word, over pattern, strobes with pattern, expected result
    logic [15:0] dc [6] = '{16'h0081, 16'h0081, 16'h0001, 16'h0011, 16'h0011, 16'h0010};
    logic [3:0] dp [6] = '{4'h7, 4'hf, 4'h4, 4'h1, 4'h1, 4'hf};
    int dn [6] = '{128, 1, 1, 1, 2, 128};
    logic de [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    gcd_config_regs u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_apb(apb), .o_pready(o_pready),
        .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_mod_tick(mod_tick),
        .i_chop_start(chop_start), .i_conv_strobe(conv_strobe), .i_ch_over(ch_over),
        .o_cfg(cfg), .o_chop_settled(settled), .o_detect_pulse(det_pulse),
        .o_detect_seen(det_seen));

    initial forever #25 i_mclk = ~i_mclk;

    // run needs about 1400 cycles; limit leaves ample margin
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (det_pulse === 1'b1) np <= np + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // caller sits just after a rising edge; one idle cycle follows each transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dd,
        input logic [3:0] ss);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: dd, pstrb: ss};
        @(posedge i_mclk);
        apb.penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1) @(posedge i_mclk);
        rd = o_prdata;
        err = o_pslverr;
        apb <= '0;
        @(posedge i_mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] dd);
        xfer(1'b1, a, {16'h0000, dd}, 4'hf);
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 32'h0, 4'h0);
        check(n, rd, {16'h0000, e});
        check("rd_err", err, 32'h0);
    endtask

    task automatic tick();
        mod_tick <= 1'b1;
        @(posedge i_mclk);
        mod_tick <= 1'b0;
        @(posedge i_mclk);
    endtask

    initial begin
        void'($urandom(32'hc4d7));
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        rdchk("gain_rst", GAIN_ADDR, 16'h0000);
        rdchk("spare_rst", SPARE_ADDR, 16'h0000);
        rdchk("cfg_rst", CFG_ADDR, 16'h0600);
        check("factor_rst", cfg.gain_factor, 32'h01010101);
        check("delay_rst", 32'(cfg.chop_settle_delay), 32'h10);
        check("en_rst", {cfg.chop_enable, cfg.detect_require_all, cfg.detect_mode_enable},
            32'h0);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            g = {1'b0, 3'(c + 3), 1'b0, 3'(c + 2), 1'b0, 3'(c + 1), 1'b0, 3'(c)};
            wr(GAIN_ADDR, g);
            for (int m = 0; m < 4; m++)
                check("gain_factor", cfg.gain_factor[m], 32'h1 << ((c + m) % 8));
            rdchk("gain_rd", GAIN_ADDR, g);
        end
        $display("test gain done");
        for (int c = 0; c < 16; c++) begin
            wr(CFG_ADDR, {3'h0, 4'(c), 2'h0, 3'(c), 3'(c), 1'b0});
            check("settle", 32'(cfg.chop_settle_delay), 32'h2 << c);
            check("hits", 32'(cfg.detect_hit_count), 32'h1 << (c % 8));
            check("window", 32'(cfg.detect_window_length), 32'(wt[c % 8]));
        end
        $display("test cfg fields done");
        // random words and byte strobes; spare low half and cfg bits 15:13 written as zero
        for (int i = 0; i < 60; i++) begin
            j = (i < 3) ? i : $urandom_range(2);
            s = (i < 3) ? 4'hf : 4'($urandom);
            d = $urandom;
            if (j == 1) d[15:0] = 16'h0000;
            if (j == 2) d[15:13] = 3'h0;
            xfer(1'b1, adr[j], d, s);
            if (s[0]) shadow[j][7:0] = d[7:0];
            if (s[1]) shadow[j][15:8] = d[15:8];
            if (i % 10 == 9) begin
                xfer(1'b1, 8'h1c - 8'(i % 3), $urandom, 4'hf);
                check("slverr", err, 32'h1);
            end
            // early reads stay on words already written, so no unknown is expected
            k = (i < 3) ? i : $urandom_range(2);
            rdchk("rand_rd", adr[k], shadow[k]);
        end
        $display("test random done");
        i_rst_n <= 1'b0;
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        rdchk("gain_rerst", GAIN_ADDR, 16'h0000);
        rdchk("spare_rerst", SPARE_ADDR, 16'h0000);
        rdchk("cfg_rerst", CFG_ADDR, 16'h0600);
        $display("test reset again done");
        // enabling alone does not start settling; the rewrite restarts it
        wr(CFG_ADDR, 16'h0100);
        wr(CFG_ADDR, 16'h0100);
        tick();
        repeat (4) @(posedge i_mclk);
        check("settle_early", settled, 32'h0);
        tick();
        repeat (3) @(posedge i_mclk);
        check("settle_done", settled, 32'h1);
        chop_start <= 1'b1;
        @(posedge i_mclk);
        chop_start <= 1'b0;
        repeat (2) @(posedge i_mclk);
        check("settle_restart", settled, 32'h0);
        tick();
        tick();
        repeat (3) @(posedge i_mclk);
        check("settle_again", settled, 32'h1);
        wr(CFG_ADDR, 16'h0000);
        @(posedge i_mclk);
        check("chop_off", settled, 32'h0);
        $display("test chop done");
        for (int i = 0; i < 6; i++) begin
            wr(CFG_ADDR, dc[i]);
            repeat (2) @(posedge i_mclk);
            p0 = np;
            for (int t = 0; t < 128; t++) begin
                conv_strobe <= 1'b1;
                ch_over <= (t < dn[i]) ? dp[i] : 4'h0;
                @(posedge i_mclk);
            end
            conv_strobe <= 1'b0;
            repeat (4) @(posedge i_mclk);
            check("seen", det_seen, 32'(de[i]));
            check("pulses", 32'(np - p0), 32'(de[i]));
        end
        $display("test detect done");
        end_of_test();
    end
endmodule

// File: bench/gcd_config_regs_sva.sv
// concurrent checks on the ports of the gain / chop / detect register bank
// assumes one clock and an APB master on i_apb; bound to the top module
module gcd_config_regs_sva
    import gcd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire gcd_apb_req_t i_apb,
    input wire logic [DATA_W-1:0] o_prdata,
    input wire logic o_pslverr,
    input wire gcd_cfg_t o_cfg
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    localparam logic [WINDOW_W-1:0] WTAB [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
        12'h500, 12'h700, 12'ha00, 12'he00};
    wire logic [REG_W-1:0] wd = i_apb.pwdata[REG_W-1:0];
    wire logic acc = i_apb.psel && i_apb.penable;
    wire logic hit = i_apb.paddr == GAIN_ADDR || i_apb.paddr == SPARE_ADDR
        || i_apb.paddr == CFG_ADDR;
    // full-word write only; byte strobes are left to the bench readback
    sequence s_wr(a);
        acc && i_apb.pwrite && i_apb.paddr == a && i_apb.pstrb[1:0] == 2'b11;
    endsequence
    property p_gain;
        s_wr(GAIN_ADDR) |=> o_cfg.gain_code == {$past(wd[14:12]), $past(wd[10:8]),
            $past(wd[6:4]), $past(wd[2:0])};
    endproperty
    a_gain: assert property (p_gain) else $error("gain code mismatch");
    property p_factor;
        o_cfg.gain_factor == {FACTOR_ONE << o_cfg.gain_code[3], FACTOR_ONE << o_cfg.gain_code[2],
            FACTOR_ONE << o_cfg.gain_code[1], FACTOR_ONE << o_cfg.gain_code[0]};
    endproperty
    a_factor: assert property (p_factor) else $error("gain factor wrong");
    property p_delay;
        s_wr(CFG_ADDR) |=> o_cfg.chop_settle_delay == SETTLE_BASE << $past(wd[12:9]);
    endproperty
    a_delay: assert property (p_delay) else $error("settle delay wrong");
    property p_flags;
        s_wr(CFG_ADDR) |=> o_cfg.chop_enable == $past(wd[8])
            && o_cfg.detect_require_all == $past(wd[7]) && o_cfg.detect_mode_enable == $past(wd[0]);
    endproperty
    a_flags: assert property (p_flags) else $error("enable flags wrong");
    property p_hits;
        s_wr(CFG_ADDR) |=> o_cfg.detect_hit_count == FACTOR_ONE << $past(wd[6:4]);
    endproperty
    a_hits: assert property (p_hits) else $error("hit count wrong");
    property p_win;
        s_wr(CFG_ADDR) |=> o_cfg.detect_window_length == WTAB[$past(wd[3:1])];
    endproperty
    a_win: assert property (p_win) else $error("window length wrong");
    property p_keep;
        !(acc && i_apb.pwrite && i_apb.paddr == GAIN_ADDR) |=> $stable(o_cfg.gain_code);
    endproperty
    a_keep: assert property (p_keep) else $error("gain changed without write");
    property p_err;
        acc && !hit |-> o_pslverr && o_prdata == '0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule

bind gcd_config_regs gcd_config_regs_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_apb(i_apb), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_cfg(o_cfg));

// File: rtl/gcd_config_regs.sv
// gain, spare and chop/detect configuration words behind an APB slave,
// plus the chop settling sequencer and current-detect evaluator they steer
// assumes tick, strobe and comparator inputs come from logic on i_mclk
//
// Chosen here: register access over APB.
module gcd_config_regs
    import gcd_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire gcd_apb_req_t i_apb,
    output logic o_pready,
    output logic [DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_mod_tick,
    input wire logic i_chop_start,
    input wire logic i_conv_strobe,
    input wire logic [NUM_CH-1:0] i_ch_over,
    output gcd_cfg_t o_cfg,
    output logic o_chop_settled,
    output logic o_detect_pulse,
    output logic o_detect_seen
);

    function automatic logic [FACTOR_W-1:0] pow2_code(input logic [GAIN_CODE_W-1:0] code);
        pow2_code = FACTOR_ONE << code;
    endfunction

    function automatic logic [REG_W-1:0] merge_lanes(input logic [REG_W-1:0] old_val,
                                                     input logic [REG_W-1:0] new_val,
                                                     input logic [REG_W-1:0] mask);
        merge_lanes = (old_val & ~mask) | (new_val & mask);
    endfunction

    function automatic logic [WINDOW_W-1:0] window_len(input logic [LEN_CODE_W-1:0] code);
        logic [WINDOW_W-1:0] len;
        len = WIN_0;
        unique case (code)
            3'h0: len = WIN_0;
            3'h1: len = WIN_1;
            3'h2: len = WIN_2;
            3'h3: len = WIN_3;
            3'h4: len = WIN_4;
            3'h5: len = WIN_5;
            3'h6: len = WIN_6;
            3'h7: len = WIN_7;
        endcase
        window_len = len;
    endfunction

    logic [REG_W-1:0] gain_reg;
    logic [REG_W-1:0] spare_reg;
    logic [REG_W-1:0] cfg_reg;
    logic [REG_W-1:0] next_gain;
    logic [REG_W-1:0] next_spare;
    logic [REG_W-1:0] next_cfg;
    logic [REG_W-1:0] lane_mask;
    logic [REG_W-1:0] rd_mux;
    logic [DATA_W-1:0] prdata;
    logic err_q;

    logic setup_ph;
    logic access_ph;
    logic sel_gain;
    logic sel_spare;
    logic sel_cfg;
    logic addr_hit;
    logic wr_en;
    logic cfg_written;

    // bus decode
    assign setup_ph = i_apb.psel & ~i_apb.penable;
    assign access_ph = i_apb.psel & i_apb.penable;
    assign sel_gain = (i_apb.paddr == GAIN_ADDR);
    assign sel_spare = (i_apb.paddr == SPARE_ADDR);
    assign sel_cfg = (i_apb.paddr == CFG_ADDR);
    assign addr_hit = sel_gain | sel_spare | sel_cfg;
    // zero wait states: the write lands at the single access edge
    assign wr_en = access_ph & i_apb.pwrite & addr_hit;
    assign cfg_written = wr_en & sel_cfg;

    // only the low two byte lanes carry register bits; upper strobes are ignored
    assign lane_mask = {{8{i_apb.pstrb[1]}}, {8{i_apb.pstrb[0]}}};
    assign next_gain = merge_lanes(gain_reg, i_apb.pwdata[REG_W-1:0], lane_mask);
    assign next_spare = merge_lanes(spare_reg, i_apb.pwdata[REG_W-1:0], lane_mask);
    assign next_cfg = merge_lanes(cfg_reg, i_apb.pwdata[REG_W-1:0], lane_mask);

    assign rd_mux = sel_gain ? gain_reg :
                    sel_spare ? spare_reg :
                    sel_cfg ? cfg_reg : '0;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_reg <= GAIN_RST;
        end else if (wr_en && sel_gain) begin
            gain_reg <= next_gain;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            spare_reg <= SPARE_RST;
        end else if (wr_en && sel_spare) begin
            spare_reg <= next_spare;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_reg <= CFG_RST;
        end else if (cfg_written) begin
            cfg_reg <= next_cfg;
        end
    end

    // read data sampled in setup, stable through access
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata <= '0;
            err_q <= 1'b0;
        end else if (setup_ph) begin
            prdata <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
            err_q <= ~addr_hit;
        end
    end

    assign o_pready = access_ph;
    assign o_prdata = prdata;
    // unmapped addresses: read zero, write dropped, error flagged
    assign o_pslverr = access_ph & err_q;

    // decoded configuration
    logic [LEN_CODE_W-1:0] len_code;
    logic [DLY_W-1:0] dly_code;
    logic [HIT_CODE_W-1:0] hit_code;

    assign len_code = cfg_reg[LEN_LSB +: LEN_CODE_W];
    assign dly_code = cfg_reg[DLY_LSB +: DLY_W];
    assign hit_code = cfg_reg[HIT_LSB +: HIT_CODE_W];

    assign o_cfg.gain_code[3] = gain_reg[CH3_LSB +: GAIN_CODE_W];
    assign o_cfg.gain_factor[3] = pow2_code(gain_reg[CH3_LSB +: GAIN_CODE_W]);
    assign o_cfg.gain_code[2] = gain_reg[CH2_LSB +: GAIN_CODE_W];
    assign o_cfg.gain_factor[2] = pow2_code(gain_reg[CH2_LSB +: GAIN_CODE_W]);
    assign o_cfg.gain_code[1] = gain_reg[CH1_LSB +: GAIN_CODE_W];
    assign o_cfg.gain_factor[1] = pow2_code(gain_reg[CH1_LSB +: GAIN_CODE_W]);
    assign o_cfg.gain_code[0] = gain_reg[CH0_LSB +: GAIN_CODE_W];
    assign o_cfg.gain_factor[0] = pow2_code(gain_reg[CH0_LSB +: GAIN_CODE_W]);
    assign o_cfg.chop_enable = cfg_reg[CHOP_EN_BIT];
    assign o_cfg.chop_settle_delay = SETTLE_BASE << dly_code;
    assign o_cfg.detect_mode_enable = cfg_reg[DET_EN_BIT];
    assign o_cfg.detect_require_all = cfg_reg[ALL_BIT];
    assign o_cfg.detect_hit_count = pow2_code(hit_code);
    assign o_cfg.detect_window_length = window_len(len_code);

    // chop settling sequencer
    gcd_chop_state_t chop_state;
    gcd_chop_state_t next_chop_state;
    logic chop_restart;
    logic settle_reached;
    logic chop_settled;

    // while chopping is enabled, each new chop phase, or any write of the config word, starts settling over
    assign chop_restart = o_cfg.chop_enable & (i_chop_start | cfg_written);

    always_comb begin
        next_chop_state = chop_state;
        unique case (chop_state)
            CHOP_OFF: begin
                if (chop_restart) begin
                    next_chop_state = CHOP_SETTLE;
                end
            end
            CHOP_SETTLE: begin
                if (chop_restart) begin
                    next_chop_state = CHOP_SETTLE;
                end else if (settle_reached) begin
                    next_chop_state = CHOP_MEASURE;
                end
            end
            CHOP_MEASURE: begin
                if (chop_restart) begin
                    next_chop_state = CHOP_SETTLE;
                end
            end
        endcase
        // disabled chopping holds the sequencer off
        if (!o_cfg.chop_enable) begin
            next_chop_state = CHOP_OFF;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chop_state <= CHOP_OFF;
            chop_settled <= 1'b0;
        end else begin
            chop_state <= next_chop_state;
            chop_settled <= (next_chop_state == CHOP_MEASURE);
        end
    end

    // count modulator periods up to the delay
    gcd_event_counter #(.W(SETTLE_W)) u_settle (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clear(chop_restart | (chop_state != CHOP_SETTLE)),
        .i_tick(i_mod_tick & (chop_state == CHOP_SETTLE) & ~chop_restart),
        .i_target(o_cfg.chop_settle_delay),
        .o_count(),
        .o_reached(settle_reached)
    );

    assign o_chop_settled = chop_settled;

    // current-detect evaluator
    gcd_det_state_t det_state;
    gcd_det_state_t next_det_state;
    logic conv_hit;
    logic window_done;
    logic det_clear;
    logic [WINDOW_W-1:0] hit_total;
    logic enough_hits;
    logic detect_pulse;
    logic detect_seen;

    // any channel or all channels over threshold
    assign conv_hit = o_cfg.detect_require_all ? (&i_ch_over) : (|i_ch_over);
    // compare hits against the needed count
    assign enough_hits = (hit_total >= WINDOW_W'(o_cfg.detect_hit_count));
    assign det_clear = (det_state == DET_OFF) | window_done | cfg_written;

    always_comb begin
        next_det_state = det_state;
        unique case (det_state)
            DET_OFF: begin
                if (o_cfg.detect_mode_enable) begin
                    next_det_state = DET_MEASURE;
                end
            end
            DET_MEASURE: begin
                next_det_state = DET_MEASURE;
            end
        endcase
        if (!o_cfg.detect_mode_enable) begin
            next_det_state = DET_OFF;
        end
    end

    gcd_event_counter #(.W(WINDOW_W)) u_window (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clear(det_clear),
        .i_tick(i_conv_strobe & (det_state == DET_MEASURE)),
        .i_target(o_cfg.detect_window_length),
        .o_count(),
        .o_reached(window_done)
    );

    // hits saturate rather than wrap over a long window
    gcd_event_counter #(.W(WINDOW_W)) u_hits (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clear(det_clear),
        .i_tick(i_conv_strobe & conv_hit & (det_state == DET_MEASURE)),
        .i_target(WINDOW_W'(o_cfg.detect_hit_count)),
        .o_count(hit_total),
        .o_reached()
    );

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            det_state <= DET_OFF;
            detect_pulse <= 1'b0;
            detect_seen <= 1'b0;
        end else begin
            det_state <= next_det_state;
            detect_pulse <= (det_state == DET_MEASURE) & window_done & enough_hits & ~cfg_written;
            if (!o_cfg.detect_mode_enable) begin
                detect_seen <= 1'b0;
            end else if ((det_state == DET_MEASURE) && window_done && !cfg_written) begin
                detect_seen <= enough_hits;
            end
        end
    end

    assign o_detect_pulse = detect_pulse;
    assign o_detect_seen = detect_seen;

endmodule

// File: rtl/gcd_event_counter.sv
// counts tick events, saturating at all ones, and flags while the count is at or past the target
// assumes ticks are single-cycle pulses on the same clock
module gcd_event_counter
    import gcd_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [W-1:0] i_target,
    output logic [W-1:0] o_count,
    output logic o_reached
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic at_max;

    assign at_max = &count;
    // a tick in the clearing cycle starts the new run, so it is not lost
    assign next_count = i_clear ? W'(i_tick) :
                        (i_tick && !at_max) ? W'(count + 1'b1) : count;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_count = count;
    assign o_reached = (count >= i_target);

endmodule

// File: rtl/gcd_pkg.sv
// constants, field layout and carrier types for the gain / chop / detect register bank
// assumes one clock domain; APB data 32 bits, registers 16 bits in the low half
package gcd_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int REG_W = 16;

    // printed word indices; byte address is four times the index
    localparam int GAIN_IDX = 4;
    localparam int SPARE_IDX = 5;
    localparam int CFG_IDX = 6;
    localparam logic [ADDR_W-1:0] GAIN_ADDR = 8'(GAIN_IDX * 4);
    localparam logic [ADDR_W-1:0] SPARE_ADDR = 8'(SPARE_IDX * 4);
    localparam logic [ADDR_W-1:0] CFG_ADDR = 8'(CFG_IDX * 4);

    localparam logic [REG_W-1:0] GAIN_RST = 16'h0000;
    localparam logic [REG_W-1:0] SPARE_RST = 16'h0000;
    localparam logic [REG_W-1:0] CFG_RST = 16'h0600;

    // gain register fields
    localparam int GAIN_CODE_W = 3;
    localparam int CH3_LSB = 12;
    localparam int CH2_LSB = 8;
    localparam int CH1_LSB = 4;
    localparam int CH0_LSB = 0;
    localparam int NUM_CH = 4;

    // chop and detect register fields
    localparam int DLY_LSB = 9;
    localparam int DLY_W = 4;
    localparam int CHOP_EN_BIT = 8;
    localparam int ALL_BIT = 7;
    localparam int HIT_LSB = 4;
    localparam int HIT_CODE_W = 3;
    localparam int LEN_LSB = 1;
    localparam int LEN_CODE_W = 3;
    localparam int DET_EN_BIT = 0;

    // decoded widths and bases
    localparam int FACTOR_W = 8;
    localparam int SETTLE_W = 17;
    localparam int WINDOW_W = 12;
    localparam logic [FACTOR_W-1:0] FACTOR_ONE = 8'h01;
    localparam logic [SETTLE_W-1:0] SETTLE_BASE = 17'h00002;

    // detect window lengths in conversion periods
    localparam logic [WINDOW_W-1:0] WIN_0 = 12'h080;
    localparam logic [WINDOW_W-1:0] WIN_1 = 12'h100;
    localparam logic [WINDOW_W-1:0] WIN_2 = 12'h200;
    localparam logic [WINDOW_W-1:0] WIN_3 = 12'h300;
    localparam logic [WINDOW_W-1:0] WIN_4 = 12'h500;
    localparam logic [WINDOW_W-1:0] WIN_5 = 12'h700;
    localparam logic [WINDOW_W-1:0] WIN_6 = 12'ha00;
    localparam logic [WINDOW_W-1:0] WIN_7 = 12'he00;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0] pstrb;
    } gcd_apb_req_t;

    typedef struct packed {
        logic [NUM_CH-1:0][GAIN_CODE_W-1:0] gain_code;
        logic [NUM_CH-1:0][FACTOR_W-1:0] gain_factor;
        logic chop_enable;
        logic [SETTLE_W-1:0] chop_settle_delay;
        logic detect_mode_enable;
        logic detect_require_all;
        logic [FACTOR_W-1:0] detect_hit_count;
        logic [WINDOW_W-1:0] detect_window_length;
    } gcd_cfg_t;

    typedef enum logic [1:0] {CHOP_OFF, CHOP_SETTLE, CHOP_MEASURE} gcd_chop_state_t;
    typedef enum logic {DET_OFF, DET_MEASURE} gcd_det_state_t;

endpackage
